// >>> dfs_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// shared constants and types of the drive fault supervisor
package dfs_pkg;

  // logic clock rate, 20 mhz (50 ns period)
  localparam int unsigned CLK_KHZ    = 20000;
  // stage and operation time limits, in milliseconds
  localparam int unsigned SPIN12_MS  = 5000;   // start to 12 rpm
  localparam int unsigned SPIN94_MS  = 60000;  // 12 rpm to speed good
  localparam int unsigned SPIN100_MS = 50000;  // speed good to full speed
  localparam int unsigned ISEEK_MS   = 2000;   // initial seek
  localparam int unsigned RTZ_MS     = 2000;   // return to zero
  localparam int unsigned SEEK_MS    = 200;    // ordinary seek
  // cycles a level check waits for the input synchronisers to settle
  localparam logic [31:0] CHECK_CYC  = 32'h0000_0004;

  // highest legal cylinder address (744)
  localparam logic [9:0]  MAX_CYL    = 10'h2e8;

  // fault codes shown on the indicators and the panel
  localparam logic [7:0] FC_NONE   = 8'h00;
  localparam logic [7:0] FC_PWR    = 8'h31;
  localparam logic [7:0] FC_MEM    = 8'h32;
  localparam logic [7:0] FC_LOCK   = 8'h33;
  localparam logic [7:0] FC_ACCEL  = 8'h3c;
  localparam logic [7:0] FC_SPIN12 = 8'h34;
  localparam logic [7:0] FC_SPIN94 = 8'h35;
  localparam logic [7:0] FC_SPINFL = 8'h36;
  localparam logic [7:0] FC_ISEEK  = 8'h3f;
  localparam logic [7:0] FC_ISKTO  = 8'h37;
  localparam logic [7:0] FC_CAL    = 8'h3a;
  localparam logic [7:0] FC_CTL1   = 8'h11;
  localparam logic [7:0] FC_CTL2   = 8'h12;
  localparam logic [7:0] FC_OFFTRK = 8'h13;
  localparam logic [7:0] FC_WUNSAF = 8'h14;
  localparam logic [7:0] FC_PROT   = 8'h15;
  localparam logic [7:0] FC_MHEAD  = 8'h16;
  localparam logic [7:0] FC_POSHT  = 8'h17;
  localparam logic [7:0] FC_SPMOT  = 8'h1f;
  localparam logic [7:0] FC_RTZTO  = 8'h21;
  localparam logic [7:0] FC_SEEKTO = 8'h22;
  localparam logic [7:0] FC_SPDNG  = 8'h23;
  localparam logic [7:0] FC_GBSEEK = 8'h24;
  localparam logic [7:0] FC_GBLIN  = 8'h25;
  localparam logic [7:0] FC_ILLCYL = 8'h27;
  localparam logic [7:0] FC_OVSHT  = 8'h2b;

  // register offsets and reset values
  localparam logic [3:0] REG_CODE  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h1;
  localparam logic [3:0] REG_CTRL  = 4'h2;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam int unsigned CTRL_PROT = 0;  // write protect bit

  // power-up and run states, one-hot
  typedef enum logic [8:0] {
    ST_PWR   = 9'h001,
    ST_MEM   = 9'h002,
    ST_LOCK  = 9'h004,
    ST_ACCEL = 9'h008,
    ST_SPD94 = 9'h010,
    ST_SPDFL = 9'h020,
    ST_ISEEK = 9'h040,
    ST_RDY   = 9'h080,
    ST_HALT  = 9'h100
  } dfs_state_e;

  // controller command codes
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_SEEK  = 3'h1,
    OP_RTZ   = 3'h2,
    OP_OFFS  = 3'h3,
    OP_READ  = 3'h4,
    OP_WRITE = 3'h5
  } dfs_op_e;

  // one controller command
  typedef struct packed {
    logic      valid;
    dfs_op_e   op;
    logic [9:0] cyl;
  } dfs_cmd_s;

  // drive sensor pins
  typedef struct packed {
    logic power_good;
    logic mpu_irq;
    logic mem_ok;
    logic mem_fail;
    logic lock_current;
    logic accel_ok;
    logic spin_12rpm;
    logic spindle_speed_good;
    logic spin_full;
    logic seek_done;
    logic seek_fail;
    logic cal_fail;
    logic off_track;
    logic write_unsafe;
    logic multi_head;
    logic positioner_heat;
    logic spindle_motor_fault;
    logic off_cylinder;
    logic guard_band;
  } dfs_sense_s;

  // status register layout
  typedef struct packed {
    logic protect;
    logic writing;
    logic reading;
    logic offset;
    logic busy;
    logic seek_fault;
    logic device_fault;
    logic ready;
  } dfs_stat_s;

endpackage

// >>> dfs_sync.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser, one lane per bit
module dfs_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // pins and settled copy
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // per-bit lanes; first stage is read only by the second
  for (genvar i = 0; i < W; i++) begin : g_lane
    logic meta_r;  // first stage
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        meta_r <= 1'b0;
        q_o[i] <= 1'b0;
      end else begin
        meta_r <= d_i[i];
        q_o[i] <= meta_r;
      end
    end
  end

endmodule

// >>> dfs_supervisor.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// Behaviour
// - bad power or stray interrupt during power-up gives 31
// - memory check failure gives 32
// - actuator lock held gives 33
// - spindle not ready to accelerate gives 3c
// - no 12 rpm within 5 s gives 34
// - no 94% speed within 60 s gives 35
// - no full speed within 50 s gives 36
// - initial seek fails 3f, late 37
// - calibration seek or save failure gives 3a
// - move command while busy or faulted gives 11
// - illegal read or write command gives 12
// - off-track while writing gives 13
// - write circuit fault gives 14
// - write under protection rejected with 15
// - several heads selected gives 16
// - ready overheat 17, spindle fault 1f, not ready
// - return to zero timeout gives 21
// - seek timeout gives 22
// - overshoot in linear mode gives 2b
// - seek without speed good gives 23
// - guard band gives 24 seeking, 25 linear
// - cylinder above 744 gives 27
// - return to zero limit 2 s
// - seek limit 200 ms
module dfs_supervisor #(
  parameter int unsigned T_SPIN12  = dfs_pkg::SPIN12_MS * dfs_pkg::CLK_KHZ,
  parameter int unsigned T_SPIN94  = dfs_pkg::SPIN94_MS * dfs_pkg::CLK_KHZ,
  parameter int unsigned T_SPIN100 = dfs_pkg::SPIN100_MS * dfs_pkg::CLK_KHZ,
  parameter int unsigned T_ISEEK   = dfs_pkg::ISEEK_MS * dfs_pkg::CLK_KHZ,
  parameter int unsigned T_RTZ     = dfs_pkg::RTZ_MS * dfs_pkg::CLK_KHZ,
  parameter int unsigned T_SEEK    = dfs_pkg::SEEK_MS * dfs_pkg::CLK_KHZ
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // drive sensor pins
  input  wire dfs_pkg::dfs_sense_s sense_i,
  // controller commands, same clock
  input  wire dfs_pkg::dfs_cmd_s cmd_i,
  input  wire logic              op_end_i,
  // register port
  input  wire logic [3:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  // indicators and status
  output logic      [7:0]        fault_code_o,
  output logic      [6:0]        led_o,
  output logic                   ready_o,
  output logic                   busy_o,
  output logic                   seek_fault_o,
  output logic                   device_fault_o
);

  //////////////////////////////////////////////////////////////////////////
  // limits as last-cycle counts
  localparam logic [31:0] LIM_SPIN12  = 32'(T_SPIN12 - 1);
  localparam logic [31:0] LIM_SPIN94  = 32'(T_SPIN94 - 1);
  localparam logic [31:0] LIM_SPIN100 = 32'(T_SPIN100 - 1);
  localparam logic [31:0] LIM_ISEEK   = 32'(T_ISEEK - 1);
  localparam logic [31:0] LIM_RTZ     = 32'(T_RTZ - 1);
  localparam logic [31:0] LIM_SEEK    = 32'(T_SEEK - 1);

  logic [$bits(dfs_pkg::dfs_sense_s)-1:0] sense_q;  // settled pins
  dfs_pkg::dfs_sense_s s;                           // settled, by field
  dfs_pkg::dfs_state_e state_r;                     // sequence state
  dfs_pkg::dfs_state_e state_nxt;
  logic [31:0]         tmr_r;                       // stage/operation timer
  logic [7:0]          code_r;                      // latched fault code
  logic [7:0]          flt_c;                       // fault seen now
  logic [7:0]          cmd_flt_c;                   // fault of this command
  logic [7:0]          ctrl_r;                      // control register
  logic                busy_r;                      // seek or rtz in flight
  logic                rtz_r;                       // flight is rtz
  logic                offset_r;                    // offset applied
  logic                reading_r;
  logic                writing_r;
  logic                ready_r;
  logic                seek_fault_r;
  logic                device_fault_r;
  logic [7:0]          rdata_r;
  logic                prot;                        // write protect
  logic                cmd_move;                    // seek, rtz or offset
  logic                cmd_rw;                      // read or write
  logic                acc_c;                       // command accepted
  dfs_pkg::dfs_stat_s  stat;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  dfs_sync #(
    .W ($bits(dfs_pkg::dfs_sense_s))
  ) u_sync (
    .clk_i   (mclk_i),
    .rst_b_i (rst_b_i),
    .d_i     (sense_i),
    .q_o     (sense_q)
  );

  assign s        = dfs_pkg::dfs_sense_s'(sense_q);
  assign prot     = ctrl_r[dfs_pkg::CTRL_PROT];
  assign cmd_move = cmd_i.valid && (cmd_i.op == dfs_pkg::OP_SEEK ||
                    cmd_i.op == dfs_pkg::OP_RTZ || cmd_i.op == dfs_pkg::OP_OFFS);
  assign cmd_rw   = cmd_i.valid && (cmd_i.op == dfs_pkg::OP_READ ||
                    cmd_i.op == dfs_pkg::OP_WRITE);

  //////////////////////////////////////////////////////////////////////////
  // command screening, valid only in ready
  always_comb begin
    cmd_flt_c = dfs_pkg::FC_NONE;
    if (cmd_move && (busy_r || seek_fault_r)) begin
      cmd_flt_c = dfs_pkg::FC_CTL1;
    end else if (cmd_move && cmd_i.op == dfs_pkg::OP_SEEK && !s.spindle_speed_good) begin
      cmd_flt_c = dfs_pkg::FC_SPDNG;
    end else if (cmd_move && cmd_i.op == dfs_pkg::OP_SEEK && cmd_i.cyl > dfs_pkg::MAX_CYL) begin
      cmd_flt_c = dfs_pkg::FC_ILLCYL;
    end else if (cmd_rw && (busy_r || seek_fault_r)) begin
      cmd_flt_c = dfs_pkg::FC_CTL2;
    end else if (cmd_rw && cmd_i.op == dfs_pkg::OP_WRITE && (reading_r || offset_r)) begin
      cmd_flt_c = dfs_pkg::FC_CTL2;
    end else if (cmd_rw && cmd_i.op == dfs_pkg::OP_WRITE && prot) begin
      cmd_flt_c = dfs_pkg::FC_PROT;
    end
  end

  assign acc_c = state_r == dfs_pkg::ST_RDY && flt_c == dfs_pkg::FC_NONE
                 && (cmd_move || cmd_rw);

  //////////////////////////////////////////////////////////////////////////
  // fault detection and sequencing
  always_comb begin
    flt_c     = dfs_pkg::FC_NONE;
    state_nxt = state_r;
    case (state_r)
      dfs_pkg::ST_PWR: begin
        if (s.mpu_irq || (tmr_r >= dfs_pkg::CHECK_CYC && !s.power_good)) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (tmr_r >= dfs_pkg::CHECK_CYC) begin
          state_nxt = dfs_pkg::ST_MEM;
        end
      end
      dfs_pkg::ST_MEM: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (s.mem_fail) begin
          flt_c = dfs_pkg::FC_MEM;
        end else if (s.mem_ok) begin
          state_nxt = dfs_pkg::ST_LOCK;
        end
      end
      dfs_pkg::ST_LOCK: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (tmr_r >= dfs_pkg::CHECK_CYC) begin
          if (!s.lock_current) begin
            flt_c = dfs_pkg::FC_LOCK;
          end else begin
            state_nxt = dfs_pkg::ST_ACCEL;
          end
        end
      end
      dfs_pkg::ST_ACCEL: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (tmr_r == 32'h0 && !s.accel_ok) begin
          flt_c = dfs_pkg::FC_ACCEL;
        end else if (s.spin_12rpm) begin
          state_nxt = dfs_pkg::ST_SPD94;
        end else if (tmr_r == LIM_SPIN12) begin
          flt_c = dfs_pkg::FC_SPIN12;
        end
      end
      dfs_pkg::ST_SPD94: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (s.spindle_speed_good) begin
          state_nxt = dfs_pkg::ST_SPDFL;
        end else if (tmr_r == LIM_SPIN94) begin
          flt_c = dfs_pkg::FC_SPIN94;
        end
      end
      dfs_pkg::ST_SPDFL: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (s.spin_full) begin
          state_nxt = dfs_pkg::ST_ISEEK;
        end else if (tmr_r == LIM_SPIN100) begin
          flt_c = dfs_pkg::FC_SPINFL;
        end
      end
      dfs_pkg::ST_ISEEK: begin
        if (s.mpu_irq) begin
          flt_c = dfs_pkg::FC_PWR;
        end else if (s.cal_fail) begin
          flt_c = dfs_pkg::FC_CAL;
        end else if (s.seek_fail) begin
          flt_c = dfs_pkg::FC_ISEEK;
        end else if (s.seek_done) begin
          state_nxt = dfs_pkg::ST_RDY;
        end else if (tmr_r == LIM_ISEEK) begin
          flt_c = dfs_pkg::FC_ISKTO;
        end
      end
      dfs_pkg::ST_RDY: begin
        if (s.positioner_heat) begin
          flt_c = dfs_pkg::FC_POSHT;
        end else if (s.spindle_motor_fault) begin
          flt_c = dfs_pkg::FC_SPMOT;
        end else if (s.cal_fail) begin
          flt_c = dfs_pkg::FC_CAL;
        end else if (cmd_flt_c != dfs_pkg::FC_NONE) begin
          flt_c = cmd_flt_c;
        end else if (writing_r && s.off_track) begin
          flt_c = dfs_pkg::FC_OFFTRK;
        end else if (writing_r && s.write_unsafe) begin
          flt_c = dfs_pkg::FC_WUNSAF;
        end else if ((reading_r || writing_r) && s.multi_head) begin
          flt_c = dfs_pkg::FC_MHEAD;
        end else if (s.guard_band && !seek_fault_r) begin
          flt_c = busy_r ? dfs_pkg::FC_GBSEEK : dfs_pkg::FC_GBLIN;
        end else if (!busy_r && !seek_fault_r && s.off_cylinder) begin
          flt_c = dfs_pkg::FC_OVSHT;
        end else if (busy_r && rtz_r && tmr_r == LIM_RTZ) begin
          flt_c = dfs_pkg::FC_RTZTO;
        end else if (busy_r && !rtz_r && tmr_r == LIM_SEEK) begin
          flt_c = dfs_pkg::FC_SEEKTO;
        end
      end
      dfs_pkg::ST_HALT: begin
        // not ready: every command is illegal
        if (cmd_move) begin
          flt_c = dfs_pkg::FC_CTL1;
        end else if (cmd_rw) begin
          flt_c = dfs_pkg::FC_CTL2;
        end
      end
      default: begin
        state_nxt = dfs_pkg::ST_HALT;
      end
    endcase
    // power-up faults and emergencies stop the sequence
    if (flt_c[7:4] == 4'h3 || flt_c == dfs_pkg::FC_POSHT || flt_c == dfs_pkg::FC_SPMOT) begin
      state_nxt = dfs_pkg::ST_HALT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state and timer
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_r <= dfs_pkg::ST_PWR;
      tmr_r   <= 32'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || (acc_c && cmd_move)) begin
        tmr_r <= 32'h0;
      end else if (tmr_r != 32'hffff_ffff) begin
        tmr_r <= tmr_r + 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fault code and fault flags
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      code_r         <= dfs_pkg::FC_NONE;
      seek_fault_r   <= 1'b0;
      device_fault_r <= 1'b0;
    end else if (flt_c != dfs_pkg::FC_NONE) begin
      if (code_r == dfs_pkg::FC_NONE) begin
        code_r <= flt_c;
      end
      if (flt_c[7:4] == 4'h2) begin
        seek_fault_r <= 1'b1;
      end
      if (flt_c[7:4] == 4'h1) begin
        device_fault_r <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operation tracking
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      busy_r    <= 1'b0;
      rtz_r     <= 1'b0;
      offset_r  <= 1'b0;
      reading_r <= 1'b0;
      writing_r <= 1'b0;
      ready_r   <= 1'b0;
    end else begin
      ready_r <= state_nxt == dfs_pkg::ST_RDY;
      if (acc_c && cmd_i.op == dfs_pkg::OP_OFFS) begin
        offset_r <= 1'b1;
      end else if (acc_c && cmd_move) begin
        // seek or rtz starts a flight and drops offset
        busy_r   <= 1'b1;
        rtz_r    <= cmd_i.op == dfs_pkg::OP_RTZ;
        offset_r <= 1'b0;
      end else if (busy_r && (s.seek_done || flt_c[7:4] == 4'h2 ||
                   state_nxt != dfs_pkg::ST_RDY)) begin
        // a halt also ends the flight, else the timer runs on unchecked
        busy_r <= 1'b0;
      end
      // read or write runs until the controller ends it or the state leaves ready
      if (acc_c && cmd_rw) begin
        reading_r <= cmd_i.op == dfs_pkg::OP_READ;
        writing_r <= cmd_i.op == dfs_pkg::OP_WRITE;
      end else if (op_end_i || state_r != dfs_pkg::ST_RDY) begin
        reading_r <= 1'b0;
        writing_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register port
  assign stat = '{protect: prot, writing: writing_r, reading: reading_r,
                  offset: offset_r, busy: busy_r, seek_fault: seek_fault_r,
                  device_fault: device_fault_r, ready: ready_r};

  // control register write
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= dfs_pkg::CTRL_RST;
    end else if (wr_i && addr_i == dfs_pkg::REG_CTRL) begin
      ctrl_r <= wdata_i;
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        dfs_pkg::REG_CODE: rdata_r <= code_r;
        dfs_pkg::REG_STAT: rdata_r <= stat;
        dfs_pkg::REG_CTRL: rdata_r <= ctrl_r;
        default:           rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // outputs straight from flops
  assign rdata_o        = rdata_r;
  assign fault_code_o   = code_r;
  assign led_o          = code_r[6:0];
  assign ready_o        = ready_r;
  assign busy_o         = busy_r;
  assign seek_fault_o   = seek_fault_r;
  assign device_fault_o = device_fault_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_quiet;
    code_r == dfs_pkg::FC_NONE && !s.mpu_irq;
  endsequence
  sequence s_rdy_ok;
    s_quiet ##0 state_r == dfs_pkg::ST_RDY && !s.positioner_heat
      && !s.spindle_motor_fault && !s.cal_fail;
  endsequence

  property p_pwr;
    s_quiet ##0 state_r == dfs_pkg::ST_PWR && tmr_r >= dfs_pkg::CHECK_CYC && !s.power_good
      |=> code_r == dfs_pkg::FC_PWR && state_r == dfs_pkg::ST_HALT;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power fault not coded");

  property p_mem;
    s_quiet ##0 state_r == dfs_pkg::ST_MEM && s.mem_fail |=> code_r == dfs_pkg::FC_MEM;
  endproperty
  a_mem: assert property (p_mem) else $error("memory fault not coded");

  property p_lock;
    s_quiet ##0 state_r == dfs_pkg::ST_LOCK && tmr_r >= dfs_pkg::CHECK_CYC && !s.lock_current
      |=> code_r == dfs_pkg::FC_LOCK ##1 state_r == dfs_pkg::ST_HALT;
  endproperty
  a_lock: assert property (p_lock) else $error("lock fault not coded");

  property p_spin12;
    s_quiet ##0 state_r == dfs_pkg::ST_ACCEL && tmr_r == LIM_SPIN12 && tmr_r != 32'h0
      && !s.spin_12rpm |=> code_r == dfs_pkg::FC_SPIN12;
  endproperty
  a_spin12: assert property (p_spin12) else $error("spin-up limit missed");

  property p_ctl1;
    s_rdy_ok ##0 cmd_move && busy_r |=> code_r == dfs_pkg::FC_CTL1 && device_fault_r;
  endproperty
  a_ctl1: assert property (p_ctl1) else $error("busy move not flagged");

  property p_prot;
    s_rdy_ok ##0 cmd_rw && cmd_i.op == dfs_pkg::OP_WRITE && prot && !busy_r
      && !seek_fault_r && !reading_r && !offset_r
      |=> code_r == dfs_pkg::FC_PROT && !writing_r;
  endproperty
  a_prot: assert property (p_prot) else $error("protected write taken");

  property p_cyl;
    s_rdy_ok ##0 cmd_move && cmd_i.op == dfs_pkg::OP_SEEK && !busy_r && !seek_fault_r
      && s.spindle_speed_good && cmd_i.cyl > dfs_pkg::MAX_CYL
      |=> code_r == dfs_pkg::FC_ILLCYL && seek_fault_r && !busy_r;
  endproperty
  a_cyl: assert property (p_cyl) else $error("bad cylinder accepted");

  property p_heat;
    s_quiet ##0 state_r == dfs_pkg::ST_RDY && s.positioner_heat
      |=> code_r == dfs_pkg::FC_POSHT && !ready_r;
  endproperty
  a_heat: assert property (p_heat) else $error("ready kept on overheat");

  property p_seekto;
    busy_r && !rtz_r |-> tmr_r <= LIM_SEEK;
  endproperty
  a_seekto: assert property (p_seekto) else $error("seek ran past limit");

  property p_hold;
    code_r != dfs_pkg::FC_NONE |=> $stable(code_r) [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("fault code changed");

endmodule

// >>> dfs_host.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// controller model: one command pulse at a time, same clock
module dfs_host (
  // clock
  input  wire logic         mclk_i,
  // command side
  output dfs_pkg::dfs_cmd_s cmd_o,
  output logic              op_end_o
);
  // idle bus at time zero
  initial begin
    cmd_o    = '0;
    op_end_o = 1'b0;
  end
  // legal order is left to the caller
  task automatic send(input dfs_pkg::dfs_op_e op, input logic [9:0] cyl);
    @(posedge mclk_i);
    cmd_o <= '{1'b1, op, cyl};
    @(posedge mclk_i);
    cmd_o <= '0;
  endtask
endmodule

// >>> test_dfs_supervisor.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// table of fault scenarios, each run from a fresh reset
module test_dfs_supervisor;
  localparam int unsigned TT = 40;  // shortened stage and op limits
  typedef struct packed {
    logic [18:0] s0, s1;  // sensors at power-up, then after ready
    logic [2:0]  op;
    logic [9:0]  cyl;
    logic        prot, rep;
    logic [7:0]  code;
  } dfs_tcase_s;
  localparam dfs_tcase_s TC [22] = '{
    '{19'h4fe00, 19'h4fe00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h32},
    '{19'h56e00, 19'h56e00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h34},
    '{19'h17e00, 19'h17e00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h31},
    '{19'h53e00, 19'h53e00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h33},
    '{19'h55e00, 19'h55e00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h3c},
    '{19'h57e00, 19'h57c00, 3'h1, 10'h00a, 1'b0, 1'b0, 8'h22},
    '{19'h57e00, 19'h57c00, 3'h1, 10'h00a, 1'b0, 1'b1, 8'h11},
    '{19'h57e00, 19'h57e00, 3'h1, 10'h2e9, 1'b0, 1'b0, 8'h27},
    '{19'h57e00, 19'h57600, 3'h1, 10'h005, 1'b0, 1'b0, 8'h23},
    '{19'h57e00, 19'h57e00, 3'h5, 10'h000, 1'b1, 1'b0, 8'h15},
    '{19'h57e00, 19'h57e40, 3'h5, 10'h000, 1'b0, 1'b0, 8'h13},
    '{19'h57e00, 19'h57e20, 3'h5, 10'h000, 1'b0, 1'b0, 8'h14},
    '{19'h57e00, 19'h57e10, 3'h4, 10'h000, 1'b0, 1'b0, 8'h16},
    '{19'h57e00, 19'h57e01, 3'h0, 10'h000, 1'b0, 1'b0, 8'h25},
    '{19'h57e00, 19'h57e08, 3'h0, 10'h000, 1'b0, 1'b0, 8'h17},
    '{19'h57e00, 19'h57e04, 3'h0, 10'h000, 1'b0, 1'b0, 8'h1f},
    '{19'h57600, 19'h57600, 3'h0, 10'h000, 1'b0, 1'b0, 8'h35},
    '{19'h57a00, 19'h57a00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h36},
    '{19'h57d00, 19'h57d00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h3f},
    '{19'h57c00, 19'h57c00, 3'h0, 10'h000, 1'b0, 1'b0, 8'h37},
    '{19'h57e00, 19'h57c00, 3'h2, 10'h000, 1'b0, 1'b0, 8'h21},
    '{19'h57e00, 19'h57e80, 3'h0, 10'h000, 1'b0, 1'b0, 8'h3a}
  };
  logic               mclk_i = 1'b0;  // logic clock
  logic               rst_b_i;        // sync reset
  dfs_pkg::dfs_sense_s sense_i;       // sensor pins
  dfs_pkg::dfs_cmd_s   cmd;           // from the controller model
  logic               op_end;
  logic [3:0]         addr_i;         // register port
  logic [7:0]         wdata_i, rdata_o, fault_code_o;
  logic               wr_i, rd_i;
  logic [6:0]         led_o;
  logic               ready_o, busy_o, seek_fault_o, device_fault_o;
  int                 err_count = 0;
  int                 checks_done = 0;
  // 50 ns clock
  always #25 mclk_i = ~mclk_i;
  dfs_supervisor #(.T_SPIN12(TT), .T_SPIN94(TT), .T_SPIN100(TT), .T_ISEEK(TT),
    .T_RTZ(TT), .T_SEEK(TT)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .sense_i(sense_i), .cmd_i(cmd), .op_end_i(op_end), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fault_code_o(fault_code_o), .led_o(led_o), .ready_o(ready_o), .busy_o(busy_o),
    .seek_fault_o(seek_fault_o), .device_fault_o(device_fault_o));
  dfs_host host (.mclk_i(mclk_i), .cmd_o(cmd), .op_end_o(op_end));
  //////////////////////////////////////////////////////////////////////////////
  // compare one byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask
  // read, data seen in the following cycle only
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    chk("rdata", exp, rdata_o);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    logic rdy_exp;  // ready expected at the end of a test
    {rst_b_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    sense_i = '0;
    for (int i = 0; i < 22; i++) begin
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      sense_i <= TC[i].s0;
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      // reset values and an unmapped place
      if (i == 0) begin
        reg_rd(dfs_pkg::REG_CTRL, dfs_pkg::CTRL_RST);
        reg_rd(4'hf, 8'h00);
      end
      reg_wr(dfs_pkg::REG_CTRL, {7'h00, TC[i].prot});
      // power-up runs to ready or to a halt
      for (int k = 0; k < 3000 && !ready_o && fault_code_o === 8'h00; k++)
        @(posedge mclk_i);
      sense_i <= TC[i].s1;
      repeat (5) @(posedge mclk_i);
      if (TC[i].op != 3'h0) host.send(dfs_pkg::dfs_op_e'(TC[i].op), TC[i].cyl);
      if (TC[i].rep) host.send(dfs_pkg::dfs_op_e'(TC[i].op), TC[i].cyl);
      repeat (TT + 10) @(posedge mclk_i);
      chk("code", TC[i].code, fault_code_o);
      chk("led", {1'b0, TC[i].code[6:0]}, {1'b0, led_o});
      reg_rd(dfs_pkg::REG_CODE, TC[i].code);
      // a repeated move leaves the first seek to time out as well
      chk("seek_fault", {7'h00, TC[i].code[7:4] == 4'h2 || TC[i].rep}, {7'h00, seek_fault_o});
      chk("dev_fault", {7'h00, TC[i].code[7:4] == 4'h1}, {7'h00, device_fault_o});
      // power-up halts and emergencies leave ready low
      rdy_exp = !(TC[i].code[7:4] == 4'h3 || TC[i].code == 8'h17 || TC[i].code == 8'h1f);
      chk("ready", {7'h00, rdy_exp}, {7'h00, ready_o});
      chk("busy", 8'h00, {7'h00, busy_o});
      $display("test %0d done", i);
    end
    wrap_up();
  end
endmodule
